// [shared/csd_defines.svh]
/*
 * Constants of the two-channel cycle-steal transfer engine: register
 * offsets, field positions, reset values and bus timing counts.
 * Assumes a single 25 MHz system clock and a register port that is
 * addressed by word index.
 */
// Notes on behaviour
// [RULE1] Two independent channels take the shared bus ahead of the processor.
// [RULE2] Requests come from a software request write or a selected interrupt line.
// [RULE3] Transfers ignore interrupt mask and levels and never touch pending interrupts.
// [RULE4] An enabled channel starts one unit transfer per accepted request.
// [RULE5] Requests arriving faster than transfers merge into one pending request.
// [RULE6] Addresses are 20 bit; the channel register window is never transferred.
// [RULE7] The transfer counter holds a 16-bit unit count.
// [RULE8] Sources: both external pins by edge, timers, serial, converter, software.
// [RULE9] With both channels pending, channel zero is served first.
// [RULE10] Each request moves one unit, a 16-bit word or an 8-bit byte.
// [RULE11] Software never sets both source and destination incrementing.
// [RULE12] Single mode clears enable and idles the channel on counter underflow.
// [RULE13] Repeat mode reloads the counter on underflow and stays active.
// [RULE14] Counter underflow raises the channel's transfer-complete interrupt request.
// [RULE15] First transfer after activation loads pointer and counter from reload values.
// [RULE16] Incrementing pointer always writable; fixed pointer writable only when disabled.
// [RULE17] All registers readable; enabled incrementing pointer reads the working pointer.
// [RULE18] A unit is source read cycles followed by destination write cycles.
// [RULE19] Word units at odd addresses on a 16-bit bus take one extra cycle.
// [RULE20] With an 8-bit external bus a word is two byte reads and two writes.
// [RULE21] Channel accesses to internal areas use the width set by the bus pin.
// [RULE22] Special register area or wait region access adds one bus-clock cycle.
// [RULE23] Pending bit sets on every request, clears before transfer; software only clears.
// [RULE24] Writing enable one to an active channel restarts it with fresh reloads.
// [RULE25] Each completed unit decrements the counter and advances the pointer.
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register word indices, channel n at base + n * stride
// ----------------------------------------------------------------------------
`define CSD_REG_STRIDE   4'h8
`define CSD_REG_SRC      4'h0
`define CSD_REG_DST      4'h1
`define CSD_REG_RELOAD   4'h2
`define CSD_REG_COUNT    4'h3
`define CSD_REG_CTRL     4'h4
`define CSD_REG_SELECT   4'h5

// ----------------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------------
`define CSD_CTRL_BYTE    0
`define CSD_CTRL_REPEAT  1
`define CSD_CTRL_PEND    2
`define CSD_CTRL_ENABLE  3
`define CSD_CTRL_SRC_INC 4
`define CSD_CTRL_DST_INC 5
`define CSD_CTRL_SWREQ   6

// ----------------------------------------------------------------------------
// Address map and reset values
// ----------------------------------------------------------------------------
`define CSD_PROT_LO      20'h00020
`define CSD_PROT_HI      20'h0003F
`define CSD_SFR_HI       20'h003FF
`define CSD_RST_SEL      5'h00
`define CSD_SEL_WIDTH    5
`define CSD_SRC_COUNT    32
`define CSD_RST_ADDR     20'h00000
`define CSD_RST_COUNT    16'h0000

// ----------------------------------------------------------------------------
// Bus timing: one bus cycle base, one extra for a waited area
// ----------------------------------------------------------------------------
`define CSD_CYC_BASE     2'h1
`define CSD_CYC_WAIT     2'h2

`endif

// [shared/csd_pkg.sv]
/*
 * Types of the transfer engine. Assumes csd_defines.svh for numbers.
 */
package csd_pkg;

  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic        byte_lane;
  } csd_bus_req_t;

  typedef struct packed {
    logic        byte_unit;
    logic        repeat_mode;
    logic        src_inc;
    logic        dst_inc;
  } csd_mode_t;

  typedef enum logic [4:0] {
    CSD_IDLE  = 5'b00001,
    CSD_READ  = 5'b00010,
    CSD_WRITE = 5'b00100,
    CSD_NEXT  = 5'b01000,
    CSD_DONE  = 5'b10000
  } csd_state_t;

endpackage

// [hw/csd_access.sv]
/*
 * One bus access stepper: counts the parts and wait cycles of a read or a
 * write of one unit. Assumes the shared bus answers in the cycle granted.
 */
`timescale 1ns/1ps
`include "csd_defines.svh"

module csd_access (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [19:0] addr,
  input  wire logic        byte_unit,
  input  wire logic        bus8,
  output logic             part,
  output logic             last
);

  logic [1:0] parts;
  logic [1:0] waits;
  logic [1:0] wcnt;
  logic       busy;
  logic       wait_area;

  // The register area and its neighbour region carry one software wait.
  assign wait_area = (addr <= `CSD_SFR_HI); // RULE22
  // Word units split on a narrow bus or an odd address.
  assign parts = (!byte_unit && (bus8 || addr[0])) ? 2'h2 : 2'h1; // RULE19 RULE20 RULE21
  assign waits = wait_area ? `CSD_CYC_WAIT : `CSD_CYC_BASE;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy <= 1'b0;
      part <= 1'b0;
      wcnt <= 2'h0;
    end else if (start) begin
      busy <= 1'b1;
      part <= 1'b0;
      wcnt <= 2'h1;
    end else if (busy) begin
      if (wcnt == waits) begin
        wcnt <= 2'h1;
        if (part == 1'b1 || parts == 2'h1) begin
          busy <= 1'b0;
        end else begin
          part <= 1'b1;
        end
      end else begin
        wcnt <= wcnt + 2'h1;
      end
    end
  end

  assign last = busy && (wcnt == waits) && (part == 1'b1 || parts == 2'h1);

endmodule // csd_access

// [hw/csd_top.sv]
/*
 * Two-channel cycle-steal transfer engine. Holds the channel registers, the
 * request arbiter and the bus sequencer. Assumes the processor yields the
 * shared bus whenever bus_req is high and that the data read back arrive
 * with bus_rdata in the cycle of the access.
 */
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "csd_defines.svh"

module csd_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [29:0] periph_irq,
  input  wire logic        ext_irq_pin_zero,
  input  wire logic        ext_irq_pin_one,
  input  wire logic        bus8,
  output logic             bus_req,
  output csd_pkg::csd_bus_req_t bus_out,
  input  wire logic [15:0] bus_rdata,
  output logic [1:0]       done_irq
);

  // --------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------------
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_d;
  logic [1:0] pin_fall;
  logic [1:0] pin_both;
  logic       bus8_s1;
  logic       bus8_s2;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_s1 <= 2'h3;
      pin_s2 <= 2'h3;
      pin_d  <= 2'h3;
      bus8_s1 <= 1'b0;
      bus8_s2 <= 1'b0;
    end else begin
      pin_s1 <= {ext_irq_pin_one, ext_irq_pin_zero};
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
      bus8_s1 <= bus8;
      bus8_s2 <= bus8_s1;
    end
  end

  assign pin_fall = pin_d & ~pin_s2;
  assign pin_both = pin_d ^ pin_s2;

  // --------------------------------------------------------------------------
  // Channel registers
  // --------------------------------------------------------------------------
  logic [19:0] src_ptr [2];
  logic [19:0] dst_ptr [2];
  logic [19:0] work_ptr [2];
  logic [15:0] reload [2];
  logic [15:0] count [2];
  logic [4:0]  sel [2];
  logic [1:0]  enable;
  logic [1:0]  pend;
  logic [1:0]  fresh;
  csd_pkg::csd_mode_t mode [2];

  logic        xfer_start;
  logic        xfer_ch;
  logic        start_ch;
  logic        unit_done;
  logic        underflow;
  logic [1:0]  req_ev;
  logic [1:0]  wr_ch;
  logic [3:0]  reg_idx;

  assign reg_idx = {1'b0, reg_addr[2:0]};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic        src_ev;
      logic        swreq;
      logic        restart;
      logic        is_cur;
      logic        is_new;
      logic [31:0] src_vec;

      assign wr_ch[g] = reg_wr && (reg_addr[3] == 1'(g));
      // Select code 0 is the falling pin edge; a software request needs no selection.
      assign src_vec = {periph_irq, pin_both[g], pin_fall[g]}; // RULE8
      assign src_ev  = src_vec[sel[g]]; // RULE2
      assign swreq   = wr_ch[g] && (reg_idx == `CSD_REG_CTRL) && reg_wdata[`CSD_CTRL_SWREQ]; // RULE2
      assign req_ev[g] = src_ev || swreq;
      assign restart = wr_ch[g] && (reg_idx == `CSD_REG_CTRL) && reg_wdata[`CSD_CTRL_ENABLE];
      assign is_cur  = (xfer_ch == 1'(g));
      assign is_new  = (start_ch == 1'(g));

      // Peripheral lines are only sampled; nothing here clears them.
      always_ff @(posedge clk_sys) begin // RULE3
        if (!rst_n) begin
          pend[g] <= 1'b0;
        end else if (req_ev[g]) begin
          pend[g] <= 1'b1; // RULE23 RULE5
        end else if (xfer_start && is_new) begin
          pend[g] <= 1'b0; // RULE23
        end else if (wr_ch[g] && reg_idx == `CSD_REG_CTRL && !reg_wdata[`CSD_CTRL_PEND]) begin
          pend[g] <= 1'b0; // RULE23
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          enable[g] <= 1'b0;
          fresh[g]  <= 1'b0;
          mode[g]   <= '0;
          sel[g]    <= `CSD_RST_SEL;
        end else begin
          if (wr_ch[g] && reg_idx == `CSD_REG_CTRL) begin
            enable[g] <= reg_wdata[`CSD_CTRL_ENABLE];
            fresh[g]  <= reg_wdata[`CSD_CTRL_ENABLE]; // RULE24
            mode[g]   <= '{byte_unit:   reg_wdata[`CSD_CTRL_BYTE],
                           repeat_mode: reg_wdata[`CSD_CTRL_REPEAT],
                           src_inc:     reg_wdata[`CSD_CTRL_SRC_INC],
                           dst_inc:     reg_wdata[`CSD_CTRL_DST_INC]};
          end else if (unit_done && is_cur && underflow && !mode[g].repeat_mode) begin
            enable[g] <= 1'b0; // RULE12
          end else if (xfer_start && is_new) begin
            fresh[g] <= 1'b0;
          end
          if (wr_ch[g] && reg_idx == `CSD_REG_SELECT) begin
            sel[g] <= reg_wdata[4:0];
          end
        end
      end

      // The incrementing pointer is always writable, the fixed one only when the channel is disabled.
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          src_ptr[g] <= `CSD_RST_ADDR;
          dst_ptr[g] <= `CSD_RST_ADDR;
          reload[g]  <= `CSD_RST_COUNT;
        end else if (wr_ch[g]) begin
          if (reg_idx == `CSD_REG_SRC && (mode[g].src_inc || !enable[g])) begin
            src_ptr[g] <= reg_wdata[19:0]; // RULE16
          end
          if (reg_idx == `CSD_REG_DST && (mode[g].dst_inc || !enable[g])) begin
            dst_ptr[g] <= reg_wdata[19:0]; // RULE16
          end
          if (reg_idx == `CSD_REG_RELOAD) begin
            reload[g] <= reg_wdata[15:0];
          end
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          work_ptr[g] <= `CSD_RST_ADDR;
          count[g]    <= `CSD_RST_COUNT;
        end else if (xfer_start && is_new && fresh[g]) begin
          work_ptr[g] <= mode[g].src_inc ? src_ptr[g] : dst_ptr[g]; // RULE15
          count[g]    <= reload[g]; // RULE15 RULE7
        end else if (unit_done && is_cur) begin
          work_ptr[g] <= work_ptr[g] + (mode[g].byte_unit ? 20'h00001 : 20'h00002); // RULE25
          count[g]    <= (underflow && mode[g].repeat_mode) ? reload[g] : count[g] - 16'h0001; // RULE13 RULE25
        end
      end

      assign done_irq[g] = unit_done && is_cur && underflow; // RULE14
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Arbiter and unit sequencer
  // --------------------------------------------------------------------------
  csd_pkg::csd_state_t state;
  logic        part;
  logic        acc_last;
  logic        acc_start;
  logic [15:0] data;
  logic [19:0] cur_src;
  logic [19:0] cur_dst;
  logic [19:0] cur_addr;
  logic [1:0]  ready;
  logic        protect;
  logic        out_part;
  logic [15:0] data_in;
  logic [19:0] part_addr;

  // After each unit the bus goes back to the processor for three cycles (NEXT, DONE, IDLE).
  assign ready      = pend & enable;
  assign xfer_start = (state == csd_pkg::CSD_IDLE) && (ready != 2'h0); // RULE4 RULE1
  assign start_ch   = !ready[0];
  assign underflow  = (count[xfer_ch] == 16'h0000);
  assign cur_src    = mode[xfer_ch].src_inc ? work_ptr[xfer_ch] : src_ptr[xfer_ch];
  assign cur_dst    = mode[xfer_ch].dst_inc ? work_ptr[xfer_ch] : dst_ptr[xfer_ch];
  assign cur_addr   = (state == csd_pkg::CSD_WRITE) ? cur_dst : cur_src;
  assign part_addr  = cur_addr + {19'h00000, part};
  assign protect    = (part_addr >= `CSD_PROT_LO) && (part_addr <= `CSD_PROT_HI);
  assign unit_done  = (state == csd_pkg::CSD_NEXT);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state   <= csd_pkg::CSD_IDLE;
      xfer_ch <= 1'b0;
    end else begin
      unique case (state)
        csd_pkg::CSD_IDLE: begin
          if (xfer_start) begin
            xfer_ch <= start_ch; // RULE9
            state   <= csd_pkg::CSD_READ;
          end
        end
        csd_pkg::CSD_READ: begin
          if (acc_last) begin
            state <= csd_pkg::CSD_WRITE; // RULE18
          end
        end
        csd_pkg::CSD_WRITE: begin
          if (acc_last) begin
            state <= csd_pkg::CSD_NEXT;
          end
        end
        csd_pkg::CSD_NEXT: begin
          state <= csd_pkg::CSD_DONE;
        end
        csd_pkg::CSD_DONE: begin
          state <= csd_pkg::CSD_IDLE;
        end
      endcase
    end
  end

  assign acc_start = (state == csd_pkg::CSD_IDLE && xfer_start) || (state == csd_pkg::CSD_READ && acc_last);

  csd_access u_access (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .start     (acc_start),
    .addr      (cur_addr),
    .byte_unit (mode[xfer_ch].byte_unit),
    .bus8      (bus8_s2),
    .part      (part),
    .last      (acc_last)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data <= 16'h0000;
    end else begin
      data <= data_in;
    end
  end

  // Data are taken while the registered read stands; a write launched on that edge gets them forwarded.
  assign data_in = !(bus_req && bus_out.rd) ? data : (out_part ? {bus_rdata[7:0], data[7:0]} : bus_rdata);

  // The channel register window is masked from every access.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_req <= 1'b0;
      bus_out <= '0;
      out_part <= 1'b0;
    end else begin
      bus_req <= (state == csd_pkg::CSD_READ) || (state == csd_pkg::CSD_WRITE); // RULE1
      out_part          <= part;
      bus_out.addr      <= part_addr;
      bus_out.wdata     <= part ? {8'h00, data_in[15:8]} : data_in;
      bus_out.rd        <= (state == csd_pkg::CSD_READ) && !protect; // RULE6
      bus_out.wr        <= (state == csd_pkg::CSD_WRITE) && !protect; // RULE6
      bus_out.byte_lane <= mode[xfer_ch].byte_unit || bus8_s2 || cur_addr[0]; // RULE10 RULE21
    end
  end

  // --------------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------------
  logic rch;
  assign rch = reg_addr[3];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_idx)
        `CSD_REG_SRC:    reg_rdata <= {12'h000, (enable[rch] && mode[rch].src_inc) ? work_ptr[rch] : src_ptr[rch]}; // RULE17
        `CSD_REG_DST:    reg_rdata <= {12'h000, (enable[rch] && mode[rch].dst_inc) ? work_ptr[rch] : dst_ptr[rch]}; // RULE17
        `CSD_REG_RELOAD: reg_rdata <= {16'h0000, reload[rch]};
        `CSD_REG_COUNT:  reg_rdata <= {16'h0000, count[rch]};
        `CSD_REG_CTRL:   reg_rdata <= {26'h0000000, mode[rch].dst_inc, mode[rch].src_inc, enable[rch],
                                       pend[rch], mode[rch].repeat_mode, mode[rch].byte_unit};
        `CSD_REG_SELECT: reg_rdata <= {27'h0000000, sel[rch]};
        default:         reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_prio;
    @(posedge clk_sys) disable iff (!rst_n)
      (xfer_start && ready == 2'h3) |=> (xfer_ch == 1'b0);
  endproperty
  a_prio: assert property (p_prio) else $error("channel one served before channel zero"); // RULE9

  property p_single_stop;
    @(posedge clk_sys) disable iff (!rst_n)
      (unit_done && underflow && !mode[xfer_ch].repeat_mode && !reg_wr) |=> !enable[$past(xfer_ch)];
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single mode channel still enabled"); // RULE12

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_n)
      (done_irq != 2'h0) |-> (state == csd_pkg::CSD_NEXT && underflow);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without underflow"); // RULE14

  property p_order;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(state == csd_pkg::CSD_WRITE) |-> $past(state == csd_pkg::CSD_READ);
  endproperty
  a_order: assert property (p_order) else $error("write not preceded by read"); // RULE18

  property p_pend_clr;
    @(posedge clk_sys) disable iff (!rst_n)
      (xfer_start && req_ev == 2'h0) |=> (pend[$past(start_ch)] == 1'b0);
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending bit kept after start"); // RULE23

  property p_start;
    @(posedge clk_sys) disable iff (!rst_n)
      (state == csd_pkg::CSD_IDLE && ready != 2'h0) |=> (state == csd_pkg::CSD_READ);
  endproperty
  a_start: assert property (p_start) else $error("ready request not started"); // RULE4

  property p_protect;
    @(posedge clk_sys) disable iff (!rst_n)
      (bus_out.rd || bus_out.wr) |-> !(bus_out.addr >= `CSD_PROT_LO && bus_out.addr <= `CSD_PROT_HI);
  endproperty
  a_protect: assert property (p_protect) else $error("register window reached by transfer"); // RULE6

  property p_dec;
    @(posedge clk_sys) disable iff (!rst_n)
      (unit_done && !underflow) |=> (count[$past(xfer_ch)] == $past(count[xfer_ch]) - 16'h0001);
  endproperty
  a_dec: assert property (p_dec) else $error("counter not decremented"); // RULE25

endmodule // csd_top

// [verification/csd_mem_model.sv]
/*
 * Shared-bus memory model for the transfer engine bench.
 * Assumes the engine drives bus_out only while bus_req is high and that reads are answered at once.
 */
`timescale 1ns/1ps
module csd_mem_model (
  input  wire logic                  clk_sys,
  input  wire logic                  bus_req,
  input  wire csd_pkg::csd_bus_req_t bus_out,
  output logic [15:0]                bus_rdata
);
  logic [15:0] junk = 16'hA5C3;
  function automatic logic [7:0] pat(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  // Off a read the lines change every cycle, so a stale value is never mistaken for data.
  always @(posedge clk_sys) begin
    junk <= ~{junk[14:0], junk[15]};
  end
  always_comb begin
    if (bus_req && bus_out.rd && bus_out.byte_lane) bus_rdata = {2{pat(bus_out.addr)}};
    else if (bus_req && bus_out.rd) bus_rdata = {pat(bus_out.addr + 20'h1), pat(bus_out.addr)};
    else bus_rdata = junk;
  end
endmodule // csd_mem_model

// [verification/test_csd_top.sv]
/*
 * Self-checking bench of the two-channel transfer engine: register rows, then transfers,
 * priority, bus timing and reset. Assumes csd_mem_model answers the shared bus.
 */
`timescale 1ns/1ps
`define CSD_CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("BAD %s expected %0h seen %0h", nm, e, s); end end
module test_csd_top;
  typedef struct packed { logic [3:0] a; logic wr; logic [31:0] d; logic [31:0] m; } csd_row_t;
  typedef struct packed { logic [19:0] s; logic [19:0] d; logic [7:0] c; logic b8; logic [3:0] r; logic [3:0] w; } csd_cyc_t;
  logic                  clk_sys = 1'h0;
  logic                  rst_n = 1'h0;
  logic [3:0]            reg_addr = 4'h0;
  logic [31:0]           reg_wdata = 32'h0;
  logic                  reg_wr = 1'h0;
  logic                  reg_rd = 1'h0;
  logic [31:0]           reg_rdata;
  logic [29:0]           periph_irq = 30'h0;
  logic                  ext_irq_pin_zero = 1'h1;
  logic                  bus8 = 1'h0;
  logic                  bus_req;
  csd_pkg::csd_bus_req_t bus_out;
  logic [15:0]           bus_rdata;
  logic [1:0]            done_irq;
  int                    bad_count = 0;
  int                    num_checks = 0;
  int                    rd_cyc = 0, wr_cyc = 0, prot_hits = 0, done0 = 0, done1 = 0;
  logic [19:0]           q_ra[$], q_wa[$];
  logic [15:0]           q_wd[$];
  logic [31:0]           v;
  csd_row_t rows [13] = '{'{4'h0, 1'h0, 32'h0, 32'hFFFFFFFF}, '{4'hB, 1'h0, 32'h0, 32'hFFFFFFFF},
    '{4'h4, 1'h0, 32'h0, 32'h3F}, '{4'h0, 1'h1, 32'h12345, 32'h0}, '{4'h0, 1'h0, 32'h12345, 32'hFFFFFFFF},
    '{4'hA, 1'h1, 32'h1FFFF, 32'h0}, '{4'hA, 1'h0, 32'hFFFF, 32'hFFFFFFFF}, '{4'h4, 1'h1, 32'h4, 32'h0},
    '{4'h4, 1'h0, 32'h0, 32'h4}, '{4'hE, 1'h1, 32'hFF, 32'h0}, '{4'hE, 1'h0, 32'h0, 32'hFFFFFFFF},
    '{4'h5, 1'h1, 32'h1F, 32'h0}, '{4'h5, 1'h0, 32'h1F, 32'h1F}};
  csd_cyc_t cyc [4] = '{'{20'h01001, 20'h00400, 8'h18, 1'h0, 4'h2, 4'h1},
    '{20'h01000, 20'h00400, 8'h18, 1'h1, 4'h2, 4'h2}, '{20'h01000, 20'h00100, 8'h19, 1'h0, 4'h1, 4'h2},
    '{20'h01000, 20'h00010, 8'h18, 1'h1, 4'h2, 4'h4}};

  csd_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_irq(periph_irq), .ext_irq_pin_zero(ext_irq_pin_zero),
    .ext_irq_pin_one(1'h1), .bus8(bus8), .bus_req(bus_req), .bus_out(bus_out), .bus_rdata(bus_rdata),
    .done_irq(done_irq));
  csd_mem_model mem (.clk_sys(clk_sys), .bus_req(bus_req), .bus_out(bus_out), .bus_rdata(bus_rdata));

  always #20 clk_sys = ~clk_sys;

  // --------------------------------------------------------------------------
  // Bus monitor and helpers
  // --------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (bus_req === 1'h1 && bus_out.rd === 1'h1) begin
      rd_cyc++;
      q_ra.push_back(bus_out.addr);
    end
    if (bus_req === 1'h1 && bus_out.wr === 1'h1) begin
      wr_cyc++;
      q_wa.push_back(bus_out.addr);
      q_wd.push_back(bus_out.wdata);
    end
    if ((bus_out.rd === 1'h1 || bus_out.wr === 1'h1) && bus_out.addr inside {[20'h00020:20'h0003F]})
      prot_hits++;
    done0 += int'(done_irq[0] === 1'h1);
    done1 += int'(done_irq[1] === 1'h1);
  end
  function automatic logic [7:0] pat(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  task automatic reg_w(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 v = reg_rdata & m;
    `CSD_CHK(nm, e, v)
  endtask
  task automatic pulse(input int k);
    @(posedge clk_sys);
    periph_irq[k] <= 1'h1;
    @(posedge clk_sys);
    periph_irq <= 30'h0;
  endtask
  // A unit may start a few cycles after its request, so wait for the bus to be taken and given back.
  task automatic wait_bus;
    bit seen;
    seen = 1'b0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_sys);
      if (bus_req === 1'h1) seen = 1'b1;
      else if (seen) break;
    end
  endtask
  task automatic clr;
    #1;
    rd_cyc = 0;
    wr_cyc = 0;
    done0 = 0;
    done1 = 0;
    q_ra.delete();
    q_wa.delete();
    q_wd.delete();
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    complete_run;
  end

  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].wr) reg_w(rows[i].a, rows[i].d);
      else rchk(rows[i].a, rows[i].m, rows[i].d, "row");
    end
    $display("register rows done");
    reg_w(4'h5, 32'h0);
    reg_w(4'h4, 32'h40);
    rchk(4'h4, 32'h4, 32'h4, "sw pend");
    reg_w(4'h5, 32'h0);
    reg_w(4'h4, 32'h0);
    ext_irq_pin_zero <= 1'h0;
    repeat (6) @(posedge clk_sys);
    rchk(4'h4, 32'h4, 32'h4, "pin pend");
    $display("request sources done");
    reg_w(4'h0, 32'h01000);
    reg_w(4'h1, 32'h00400);
    reg_w(4'h2, 32'h2);
    reg_w(4'h5, 32'h2);
    reg_w(4'h4, 32'h19);
    clr;
    for (int i = 0; i < 3; i++) begin
      pulse(0);
      wait_bus;
      if (i == 0) rchk(4'h0, 32'hFFFFF, 32'h01001, "work ptr");
    end
    for (int i = 0; i < 3; i++) begin
      `CSD_CHK("src rd", 20'h01000 + i, q_ra[i])
      `CSD_CHK("byte wr", pat(20'h01000 + i), q_wd[i][7:0])
    end
    `CSD_CHK("done0", 1, done0)
    rchk(4'h4, 32'h8, 32'h0, "single off");
    pulse(0);
    wait_bus;
    `CSD_CHK("units", 3, q_wa.size())
    rchk(4'h4, 32'h4, 32'h4, "pend off");
    reg_w(4'h4, 32'h0);
    rchk(4'h4, 32'h4, 32'h0, "pend clr");
    $display("single mode done");
    reg_w(4'h2, 32'h5);
    reg_w(4'h4, 32'h19);
    clr;
    pulse(0);
    wait_bus;
    pulse(0);
    wait_bus;
    reg_w(4'h4, 32'h19);
    pulse(0);
    wait_bus;
    `CSD_CHK("advance", 20'h01001, q_ra[1])
    `CSD_CHK("restart", 20'h01000, q_ra[2])
    $display("restart done");
    reg_w(4'h8, 32'h02000);
    reg_w(4'h9, 32'h03000);
    reg_w(4'hA, 32'h0);
    reg_w(4'hD, 32'h3);
    reg_w(4'hC, 32'h2A);
    clr;
    pulse(1);
    wait_bus;
    pulse(1);
    wait_bus;
    `CSD_CHK("dst inc", 20'h03002, q_wa[1])
    `CSD_CHK("word wr", {pat(20'h02001), pat(20'h02000)}, q_wd[0])
    `CSD_CHK("done1", 2, done1)
    rchk(4'hC, 32'h8, 32'h8, "repeat on");
    reg_w(4'h8, 32'h02222);
    rchk(4'h8, 32'hFFFFF, 32'h02000, "fixed lock");
    $display("repeat mode done");
    reg_w(4'h5, 32'h3);
    reg_w(4'h4, 32'h19);
    clr;
    pulse(1);
    wait_bus;
    wait_bus;
    `CSD_CHK("first", 20'h01000, q_ra[0])
    `CSD_CHK("second", 20'h02000, q_ra[1])
    $display("priority done");
    reg_w(4'hC, 32'h0);
    foreach (cyc[i]) begin
      reg_w(4'h4, 32'h0);
      reg_w(4'h0, {12'h0, cyc[i].s});
      reg_w(4'h1, {12'h0, cyc[i].d});
      reg_w(4'h4, {24'h0, cyc[i].c});
      bus8 <= cyc[i].b8;
      clr;
      pulse(1);
      wait_bus;
      `CSD_CHK("rd cyc", cyc[i].r, rd_cyc)
      `CSD_CHK("wr cyc", cyc[i].w, wr_cyc)
    end
    reg_w(4'h4, 32'h0);
    reg_w(4'h1, 32'h00030);
    reg_w(4'h4, 32'h19);
    bus8 <= 1'h0;
    pulse(1);
    wait_bus;
    `CSD_CHK("protected", 0, prot_hits)
    $display("bus timing done");
    reg_w(4'hC, 32'h2A);
    @(posedge clk_sys);
    rst_n <= 1'h0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'h1;
    rchk(4'hC, 32'h3F, 32'h0, "rst ctrl");
    rchk(4'h8, 32'hFFFFF, 32'h0, "rst src");
    `CSD_CHK("rst bus", 1'h0, bus_req)
    $display("reset done");
    complete_run;
  end
endmodule // test_csd_top
